// file: event_dispatch_pkg.sv
// Constants, types and carriers shared by the event input dispatcher.
// Assumes a single 125 MHz clock and an active-low asynchronous reset.
`default_nettype none
package event_dispatch_pkg;

    // Channel count and clocking
    localparam int NUM_EVENTS = 6;
    localparam int CLK_HZ = 125_000_000;
    localparam int HOLD_MS = 50;
    localparam int HOLD_CYCLES = HOLD_MS * (CLK_HZ / 1000);
    localparam int HOLD_CNT_W = 24;

    // Set point representation and reset values
    localparam int SP_W = 16;
    typedef logic signed [SP_W-1:0] sp_t;
    localparam sp_t SP_RESET = 16'sh0000;
    localparam sp_t SP_HI_RESET = 16'sh0514;
    localparam sp_t SP_LO_RESET = 16'shFF38;

    // Controller state reset values
    localparam logic RUN_RESET = 1'b1;
    localparam int ALARM_W = 6;
    localparam logic [ALARM_W-1:0] ALARM_RESET = 6'h00;

    // Functions that an event input may be assigned
    typedef enum logic [4:0] {
        FN_NONE,
        FN_STOP,
        FN_HAND,
        FN_LAUNCH,
        FN_INVERT,
        FN_FULL_AT,
        FN_REDUCED_AT,
        FN_LOCK,
        FN_COMMS,
        FN_LATCH,
        FN_MSP0,
        FN_MSP1,
        FN_MSP2,
        FN_RUN,
        FN_PID,
        FN_FILTER,
        FN_WATER
    } func_e;
    localparam int FN_COUNT = 17;
    localparam logic [FN_COUNT-1:0] FN_ONE = 17'h00001;

    // Set point and limit write request
    typedef struct packed {
        logic valid;
        sp_t value;
    } sp_write_s;

    // Load of the input setting range or scaling limits
    typedef struct packed {
        logic valid;
        sp_t upper;
        sp_t lower;
    } range_load_s;

    // Function outputs toward the controller core
    typedef struct packed {
        logic hand_control_select;
        logic manual_lamp;
        logic program_launch;
        logic direction_invert;
        logic full_autotune_trigger;
        logic reduced_autotune_trigger;
        logic setting_change_lock;
        logic comms_write_permit;
        logic alarm_hold_release;
        logic adaptive_pid_refresh;
        logic filter_self_adjust;
        logic water_cooling_adjust;
    } func_out_s;
    localparam func_out_s FUNC_RESET = 12'h000;

endpackage
`default_nettype wire

// file: contact_filter.sv
// One event contact: three-stage synchroniser and hold-time filter.
// Assumes the contact is asynchronous to clk; level starts off at reset.
`default_nettype none
`timescale 1ns/100ps
module contact_filter #(
    parameter int unsigned HOLD = event_dispatch_pkg::HOLD_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Contact pin
    input wire logic contact,
    // Filtered level and its edges
    output logic level,
    output logic rise,
    output logic fall
);
    import event_dispatch_pkg::*;

    logic sync1;
    logic sync2;
    logic sync3;
    logic [HOLD_CNT_W-1:0] count;
    logic differs;
    logic done;

    assign differs = (sync2 == sync3) && (sync3 != level);
    assign done = differs && (count == HOLD_CNT_W'(HOLD - 1));

    // Synchroniser chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= contact;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Hold-time counter, restarts on any bounce
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (!differs || done) begin
            count <= '0;
        end else begin
            count <= count + HOLD_CNT_W'(1);
        end
    end

    // Accepted level and edges; an on contact at power-up gives a rise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            level <= done ? sync3 : level;
            rise <= done && sync3;
            fall <= done && !sync3;
        end
    end

    chk_hold_time: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(level) |-> $past(count) == HOLD_CNT_W'(HOLD - 1) && $past(sync3) == level)
        else $error("level changed before the hold time");

    chk_edge_pair: assert property (@(posedge clk) disable iff (!rst_n)
        rise |-> level && !fall && $past(!level))
        else $error("rise without an off to on change");

endmodule // contact_filter
`default_nettype wire

// file: event_input_function_dispatch.sv
// Event input dispatcher: filters six contacts and drives the assigned functions,
// and holds the set point with its limiter. Assumes the alarm, program and tuning
// engines run on the same clock and use the registered outputs.
`default_nettype none
`timescale 1ns/100ps
module event_input_function_dispatch #(
    parameter int unsigned HOLD = event_dispatch_pkg::HOLD_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Event contacts and their assignments
    input wire logic [event_dispatch_pkg::NUM_EVENTS-1:0] event_contact,
    input wire event_dispatch_pkg::func_e event_input_function_1,
    input wire event_dispatch_pkg::func_e event_input_function_2,
    input wire event_dispatch_pkg::func_e event_input_function_3,
    input wire event_dispatch_pkg::func_e event_input_function_4,
    input wire event_dispatch_pkg::func_e event_input_function_5,
    input wire event_dispatch_pkg::func_e event_input_function_6,
    // Controller configuration and status
    input wire logic reverse_config,
    input wire logic program_done,
    input wire logic autotune_finished,
    input wire logic [event_dispatch_pkg::ALARM_W-1:0] alarm_raw,
    // Set point and limiter requests
    input wire event_dispatch_pkg::sp_write_s sp_write,
    input wire event_dispatch_pkg::sp_write_s upper_write,
    input wire event_dispatch_pkg::sp_write_s lower_write,
    input wire event_dispatch_pkg::range_load_s range_load,
    input wire logic limiter_reset,
    // Run state and lamps
    output logic run_control,
    output logic stop_lamp,
    output logic program_end,
    output logic reverse_active,
    output event_dispatch_pkg::func_out_s functions,
    output logic [event_dispatch_pkg::ALARM_W-1:0] alarm_latched,
    // Set point and limits
    output event_dispatch_pkg::sp_t setpoint,
    output event_dispatch_pkg::sp_t setpoint_upper_bound,
    output event_dispatch_pkg::sp_t setpoint_lower_bound,
    output logic sp_refused
);
    import event_dispatch_pkg::*;

    func_e cfg [NUM_EVENTS];
    logic [NUM_EVENTS-1:0] ev_level;
    logic [NUM_EVENTS-1:0] ev_rise;
    logic [NUM_EVENTS-1:0] ev_fall;
    logic [FN_COUNT-1:0] sel [NUM_EVENTS];
    logic [FN_COUNT-1:0] fn_used;
    logic [FN_COUNT-1:0] fn_lvl;
    logic [FN_COUNT-1:0] fn_rise;
    logic [FN_COUNT-1:0] fn_fall;
    logic go_stop;
    logic go_run;
    logic next_run;
    logic limits_moved;
    logic sp_out;

    assign cfg[0] = event_input_function_1;
    assign cfg[1] = event_input_function_2;
    assign cfg[2] = event_input_function_3;
    assign cfg[3] = event_input_function_4;
    assign cfg[4] = event_input_function_5;
    assign cfg[5] = event_input_function_6;

    // Per-input filter and assignment decode
    for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_event
        contact_filter #(
            .HOLD(HOLD)
        ) u_filter (
            .clk(clk),
            .rst_n(rst_n),
            .contact(event_contact[i]),
            .level(ev_level[i]),
            .rise(ev_rise[i]),
            .fall(ev_fall[i])
        );
        assign sel[i] = (cfg[i] == FN_NONE) ? '0 : (FN_ONE << cfg[i]);
    end

    // Gather levels and edges per function
    always_comb begin
        fn_used = '0;
        fn_lvl = '0;
        fn_rise = '0;
        fn_fall = '0;
        for (int i = 0; i < NUM_EVENTS; i++) begin
            fn_used = fn_used | sel[i];
            fn_lvl = fn_lvl | (sel[i] & {FN_COUNT{ev_level[i]}});
            fn_rise = fn_rise | (sel[i] & {FN_COUNT{ev_rise[i]}});
            fn_fall = fn_fall | (sel[i] & {FN_COUNT{ev_fall[i]}});
        end
    end

    // Run/stop decision, stop requests win
    assign go_stop = fn_rise[FN_STOP] || fn_fall[FN_RUN] || fn_fall[FN_LAUNCH];
    assign go_run = fn_fall[FN_STOP] || fn_rise[FN_RUN];
    assign next_run = go_stop ? 1'b0 : (go_run ? 1'b1 : run_control);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_control <= RUN_RESET;
            stop_lamp <= !RUN_RESET;
        end else begin
            run_control <= next_run;
            stop_lamp <= !next_run;
        end
    end

    // Program end flag, a new completion wins over the reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_end <= 1'b0;
        end else if (program_done) begin
            program_end <= 1'b1;
        end else if (fn_fall[FN_LAUNCH]) begin
            program_end <= 1'b0;
        end
    end

    // Effective direction
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reverse_active <= 1'b0;
        end else begin
            reverse_active <= reverse_config ^ fn_lvl[FN_INVERT];
        end
    end

    // Alarm latches run independently of run/stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_latched <= ALARM_RESET;
        end else if (fn_rise[FN_LATCH]) begin
            alarm_latched <= alarm_raw;
        end else begin
            alarm_latched <= alarm_latched | alarm_raw;
        end
    end

    // Function outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            functions <= FUNC_RESET;
        end else begin
            functions.hand_control_select <= fn_lvl[FN_HAND];
            functions.manual_lamp <= fn_lvl[FN_HAND];
            functions.direction_invert <= fn_lvl[FN_INVERT];
            functions.setting_change_lock <= fn_lvl[FN_LOCK];
            functions.comms_write_permit <= !fn_used[FN_COMMS] || fn_lvl[FN_COMMS];
            functions.alarm_hold_release <= fn_rise[FN_LATCH];
            functions.adaptive_pid_refresh <= fn_rise[FN_PID];
            if (fn_rise[FN_LAUNCH]) begin
                functions.program_launch <= 1'b1;
            end else if (fn_fall[FN_LAUNCH]) begin
                functions.program_launch <= 1'b0;
            end
            if (fn_rise[FN_FULL_AT]) begin
                functions.full_autotune_trigger <= 1'b1;
            end else if (fn_fall[FN_FULL_AT] || autotune_finished) begin
                functions.full_autotune_trigger <= 1'b0;
            end
            if (fn_rise[FN_REDUCED_AT]) begin
                functions.reduced_autotune_trigger <= 1'b1;
            end else if (fn_fall[FN_REDUCED_AT] || autotune_finished) begin
                functions.reduced_autotune_trigger <= 1'b0;
            end
            if (fn_rise[FN_FILTER]) begin
                functions.filter_self_adjust <= 1'b1;
            end else if (fn_fall[FN_FILTER]) begin
                functions.filter_self_adjust <= 1'b0;
            end
            if (fn_rise[FN_WATER]) begin
                functions.water_cooling_adjust <= 1'b1;
            end else if (fn_fall[FN_WATER]) begin
                functions.water_cooling_adjust <= 1'b0;
            end
        end
    end

    // Limits: range reload first, then unlocked writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            setpoint_upper_bound <= SP_HI_RESET;
            setpoint_lower_bound <= SP_LO_RESET;
            limits_moved <= 1'b0;
        end else if (range_load.valid) begin
            setpoint_upper_bound <= range_load.upper;
            setpoint_lower_bound <= range_load.lower;
            limits_moved <= 1'b1;
        end else begin
            if (upper_write.valid && !functions.setting_change_lock) begin
                setpoint_upper_bound <= upper_write.value;
            end
            if (lower_write.valid && !functions.setting_change_lock) begin
                setpoint_lower_bound <= lower_write.value;
            end
            limits_moved <= (upper_write.valid || lower_write.valid)
                && !functions.setting_change_lock;
        end
    end

    // Set point: clamp after a limit move or reset, else checked writes
    assign sp_out = (sp_write.value > setpoint_upper_bound)
        || (sp_write.value < setpoint_lower_bound);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            setpoint <= SP_RESET;
            sp_refused <= 1'b0;
        end else if (limits_moved || limiter_reset) begin
            if (setpoint > setpoint_upper_bound) begin
                setpoint <= setpoint_upper_bound;
            end else if (setpoint < setpoint_lower_bound) begin
                setpoint <= setpoint_lower_bound;
            end
            sp_refused <= sp_write.valid;
        end else begin
            if (sp_write.valid && !sp_out && !functions.setting_change_lock) begin
                setpoint <= sp_write.value;
            end
            sp_refused <= sp_write.valid && (sp_out || functions.setting_change_lock);
        end
    end

    chk_stop_lamp: assert property (@(posedge clk) disable iff (!rst_n)
        stop_lamp == !run_control)
        else $error("stop lamp disagrees with run state");

    chk_norm_stop: assert property (@(posedge clk) disable iff (!rst_n)
        fn_rise[FN_STOP] |=> !run_control && stop_lamp)
        else $error("normal run/stop on did not stop control");

    chk_rev_run: assert property (@(posedge clk) disable iff (!rst_n)
        fn_rise[FN_RUN] && !fn_rise[FN_STOP] && !fn_fall[FN_LAUNCH] |=> run_control)
        else $error("reverse run/stop on did not run control");

    chk_manual_lamp: assert property (@(posedge clk) disable iff (!rst_n)
        functions.manual_lamp == functions.hand_control_select)
        else $error("manual lamp disagrees with manual select");

    chk_launch_reset: assert property (@(posedge clk) disable iff (!rst_n)
        fn_fall[FN_LAUNCH] && !program_done |=> !run_control && !program_end
            && !functions.program_launch)
        else $error("program reset did not stop and clear end");

    chk_full_cancel: assert property (@(posedge clk) disable iff (!rst_n)
        fn_fall[FN_FULL_AT] && !fn_rise[FN_FULL_AT] |=> !functions.full_autotune_trigger
            ##1 functions.full_autotune_trigger == $past(fn_rise[FN_FULL_AT]))
        else $error("full autotune not cancelled on contact off");

    chk_latch_clear: assert property (@(posedge clk) disable iff (!rst_n)
        fn_rise[FN_LATCH] |=> alarm_latched == $past(alarm_raw) && functions.alarm_hold_release)
        else $error("alarm latches not released");

    chk_sp_refuse: assert property (@(posedge clk) disable iff (!rst_n)
        sp_write.valid && sp_out |=> sp_refused && $stable(setpoint))
        else $error("out of range set point accepted");

    chk_sp_inside: assert property (@(posedge clk) disable iff (!rst_n)
        !limits_moved && !$past(range_load.valid)
            && (setpoint_lower_bound <= setpoint_upper_bound) && $past(!limits_moved)
            |-> setpoint <= setpoint_upper_bound && setpoint >= setpoint_lower_bound)
        else $error("set point left outside the limits");

    chk_dir_invert: assert property (@(posedge clk) disable iff (!rst_n)
        $stable(reverse_config) && fn_lvl[FN_INVERT] ##1 $stable(reverse_config)
            |-> reverse_active != reverse_config)
        else $error("direction not inverted");

    chk_comms_permit: assert property (@(posedge clk) disable iff (!rst_n)
        fn_used[FN_COMMS] |=> functions.comms_write_permit == $past(fn_lvl[FN_COMMS]))
        else $error("comms write permit disagrees with contact");

endmodule // event_input_function_dispatch
`default_nettype wire

// file: contact_bank.sv
// Switch contact model for the six event inputs.
// Assumes the bench sets target levels and may inject short bounces.
`timescale 1ns/100ps
`default_nettype none
module contact_bank #(
    parameter int MIN_HOLD = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requested levels and injected bounces
    input wire logic [5:0] target,
    input wire logic [5:0] glitch,
    // Contact pins
    output logic [5:0] contact
);
    logic [5:0] held;
    int age [6];
    assign contact = held ^ glitch;
    always @(posedge clk or negedge rst_n) begin
        for (int i = 0; i < 6; i++) begin
            if (!rst_n) begin
                held[i] <= 1'b0;
                age[i] <= MIN_HOLD;
            end else if (target[i] != held[i] && age[i] >= MIN_HOLD) begin
                held[i] <= target[i];
                age[i] <= 0;
            end else if (age[i] < MIN_HOLD) begin
                age[i] <= age[i] + 1;
            end
        end
    end
endmodule // contact_bank
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the event input dispatcher with random contacts.
// Assumes contact_bank as switch model and a hold time cut to HOLD cycles.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module testbench;
    import event_dispatch_pkg::*;
    localparam int HOLD = 8;
    localparam int W = 3 * HOLD + 12;
    localparam int LIMIT = 20000;
    localparam int SPAN = SP_HI_RESET - SP_LO_RESET + 1;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] target = 6'h01;
    logic [5:0] glitch = 6'h00;
    logic [5:0] contact;
    func_e fa [6] = '{FN_STOP, FN_NONE, FN_NONE, FN_NONE, FN_NONE, FN_NONE};
    func_e tbl [11] = '{FN_STOP, FN_HAND, FN_LAUNCH, FN_RUN, FN_INVERT, FN_FULL_AT,
        FN_REDUCED_AT, FN_LOCK, FN_COMMS, FN_FILTER, FN_WATER};
    logic rev = 1'b0;
    logic done = 1'b0;
    logic at_fin = 1'b0;
    logic lim_rst = 1'b0;
    logic [ALARM_W-1:0] alarm_raw = 6'h00;
    sp_write_s spw = '0;
    sp_write_s upw = '0;
    sp_write_s low = '0;
    range_load_s rl = '0;
    logic run_control, stop_lamp, program_end, reverse_active, sp_refused;
    func_out_s fo;
    logic [ALARM_W-1:0] alarm_latched;
    sp_t setpoint, sp_hi, sp_lo;
    int n_errors = 0;
    int comparisons = 0;
    int n_pid = 0;
    int n_rel = 0;
    int cycles = 0;
    logic [31:0] seed = 32'hB68AE05B;

    contact_bank #(.MIN_HOLD(HOLD)) u_contact_bank (.clk(clk), .rst_n(rst_n),
        .target(target), .glitch(glitch), .contact(contact));
    event_input_function_dispatch #(.HOLD(HOLD)) u_event_input_function_dispatch (
        .clk(clk), .rst_n(rst_n), .event_contact(contact),
        .event_input_function_1(fa[0]), .event_input_function_2(fa[1]),
        .event_input_function_3(fa[2]), .event_input_function_4(fa[3]),
        .event_input_function_5(fa[4]), .event_input_function_6(fa[5]),
        .reverse_config(rev), .program_done(done), .autotune_finished(at_fin),
        .alarm_raw(alarm_raw), .sp_write(spw), .upper_write(upw), .lower_write(low),
        .range_load(rl), .limiter_reset(lim_rst), .run_control(run_control),
        .stop_lamp(stop_lamp), .program_end(program_end), .reverse_active(reverse_active),
        .functions(fo), .alarm_latched(alarm_latched), .setpoint(setpoint),
        .setpoint_upper_bound(sp_hi), .setpoint_lower_bound(sp_lo), .sp_refused(sp_refused));

    always #4 clk = ~clk;

    // Pulse outputs are counted mid-cycle, where they have settled
    always @(negedge clk) begin
        if (fo.adaptive_pid_refresh === 1'b1) n_pid++;
        if (fo.alarm_hold_release === 1'b1) n_rel++;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            print_verdict();
        end
    end

    task print_verdict();
        if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic pick(func_e f);
        case (f)
            FN_STOP: return stop_lamp;
            FN_RUN: return run_control;
            FN_HAND: return fo.hand_control_select;
            FN_LAUNCH: return fo.program_launch;
            FN_INVERT: return reverse_active;
            FN_FULL_AT: return fo.full_autotune_trigger;
            FN_REDUCED_AT: return fo.reduced_autotune_trigger;
            FN_LOCK: return fo.setting_change_lock;
            FN_COMMS: return fo.comms_write_permit;
            FN_FILTER: return fo.filter_self_adjust;
            default: return fo.water_cooling_adjust;
        endcase
    endfunction

    function automatic logic want(func_e f, logic c);
        return (f == FN_INVERT) ? (c ^ rev) : c;
    endfunction

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic use_fn(int k, func_e f);
        target = '0;
        tick(W);
        foreach (fa[j]) fa[j] = FN_NONE;
        fa[k] = f;
    endtask

    task automatic sp_req(int which, sp_t v);
        if (which == 0) spw = '{1'b1, v};
        else if (which == 1) upw = '{1'b1, v};
        else low = '{1'b1, v};
        tick(1);
        spw.valid = 1'b0;
        upw.valid = 1'b0;
        low.valid = 1'b0;
    endtask

    task automatic sp_try(sp_t v, logic ok);
        sp_t old;
        old = setpoint;
        sp_req(0, v);
        `CHECK(setpoint, ok ? v : old)
        `CHECK(sp_refused, !ok)
        tick(1);
    endtask

    initial begin
        int k;
        sp_t v;
        logic [31:0] r;
        logic [ALARM_W-1:0] a;
        func_e f;
        tick(8);
        `CHECK(run_control, RUN_RESET)
        `CHECK(stop_lamp, 1'b0)
        `CHECK(sp_hi, SP_HI_RESET)
        `CHECK(sp_lo, SP_LO_RESET)
        rst_n = 1'b1;
        tick(W);
        `CHECK(stop_lamp, 1'b1)
        target = 6'h00;
        tick(W);
        `CHECK(run_control, 1'b1)
        foreach (tbl[i]) begin
            f = tbl[i];
            r = xorshift();
            k = int'(r % 6);
            use_fn(k, f);
            rev = r[4];
            target = r[13:8] | 6'(6'h01 << k);
            tick(W);
            `CHECK(pick(f), want(f, 1'b1))
            if (f == FN_HAND) `CHECK(fo.manual_lamp, 1'b1)
            if (f == FN_INVERT) `CHECK(fo.direction_invert, 1'b1)
            if (f == FN_LAUNCH) begin
                done = 1'b1;
                tick(1);
                done = 1'b0;
                `CHECK(program_end, 1'b1)
            end
            if (f == FN_FULL_AT) begin
                at_fin = 1'b1;
                tick(1);
                at_fin = 1'b0;
                tick(1);
                `CHECK(fo.full_autotune_trigger, 1'b0)
            end
            target[k] = 1'b0;
            tick(W);
            `CHECK(pick(f), want(f, 1'b0))
            if (f == FN_LAUNCH) begin
                `CHECK(program_end, 1'b0)
                `CHECK(run_control, 1'b0)
            end
        end
        r = xorshift();
        a = r[5:0] | 6'h01;
        alarm_raw = a;
        tick(1);
        alarm_raw = '0;
        tick(1);
        `CHECK(alarm_latched, a)
        use_fn(k, FN_LATCH);
        target[k] = 1'b1;
        tick(W);
        `CHECK(alarm_latched, 6'h00)
        `CHECK(n_rel, 1)
        use_fn(k, FN_PID);
        target[k] = 1'b1;
        tick(W);
        `CHECK(n_pid, 1)
        use_fn(0, FN_STOP);
        `CHECK(n_pid, 1)
        glitch[0] = 1'b1;
        tick(HOLD - 2);
        glitch[0] = 1'b0;
        tick(W);
        `CHECK(stop_lamp, 1'b1)
        target[0] = 1'b1;
        tick(W);
        target[0] = 1'b0;
        tick(W);
        `CHECK(run_control, 1'b1)
        sp_try(sp_hi, 1'b1);
        sp_try(sp_lo, 1'b1);
        sp_try(sp_hi + 16'sh0001, 1'b0);
        sp_try(sp_lo - 16'sh0001, 1'b0);
        repeat (8) begin
            r = xorshift();
            v = sp_t'(int'(r % SPAN) + SP_LO_RESET);
            sp_try(v, 1'b1);
        end
        use_fn(2, FN_LOCK);
        target[2] = 1'b1;
        tick(W);
        sp_try(16'sh0000, 1'b0);
        target[2] = 1'b0;
        tick(W);
        sp_try(16'sh03E8, 1'b1);
        sp_req(1, 16'sh01F4);
        tick(1);
        `CHECK(sp_hi, 16'sh01F4)
        `CHECK(setpoint, 16'sh01F4)
        sp_try(16'shFF9C, 1'b1);
        sp_req(2, 16'shFFCE);
        tick(1);
        `CHECK(setpoint, 16'shFFCE)
        rl = '{1'b1, 16'sh03E8, 16'sh0000};
        tick(1);
        rl.valid = 1'b0;
        tick(1);
        `CHECK(sp_hi, 16'sh03E8)
        `CHECK(sp_lo, 16'sh0000)
        `CHECK(setpoint, 16'sh0000)
        lim_rst = 1'b1;
        sp_try(16'sh0005, 1'b0);
        lim_rst = 1'b0;
        print_verdict();
    end
endmodule // testbench
`undef CHECK
`default_nettype wire
